// *** serial_comm_pkg.sv ***
// Purpose: Shared types and constants of the serial comm unit
// Assumes: One 100 MHz system clock, registers reached as plain ports
// Notes:   Operation
// Operation
// RULE1: Line idles high; low edge starts reception
// RULE2: Length select: clear eight bits, set seven
// RULE3: Parity bit, or multiprocessor bit overriding parity
// RULE4: Stop length select: one or two stops
// RULE5: Sixteen-times clock, sample at eighth pulse
// RULE6: Transfer clock internal generator or external pin
// RULE7: External pin clock runs sixteen times bitrate
// RULE8: Output clock rises mid transmitted bit
// RULE9: Transmit disable forces data-empty flag high
// RULE10: Receive disable keeps receive flags and data
// RULE11: Disable both directions before changing format
// RULE12: External clock keeps running during initialization
// RULE13: Empty flag low: load shifter, set flag
// RULE14: Send start, data, extra bit, stops
// RULE15: Stop time, flag low: chain next frame
// RULE16: Stop time, flag high: set end, idle
// RULE17: Full when done: overrun, drop character
// RULE18: Parity mismatch: flag it, still store
// RULE19: Low stop bit: framing flag, still store
// RULE20: Clean frame: store data, set full
// RULE21: Errors never change the full flag
// RULE22: No reception while error flags remain set
// RULE23: Data bits travel least significant first
package serial_comm_pkg;

  localparam int unsigned OVERSAMPLE   = 16;
  localparam logic [3:0]  BIT_LAST     = 4'(OVERSAMPLE - 1);
  localparam logic [3:0]  SAMPLE_PHASE = 4'h7;
  localparam logic [3:0]  CLK_RISE     = 4'h8;
  localparam logic [2:0]  LAST_BIT8    = 3'h7;
  localparam logic [2:0]  LAST_BIT7    = 3'h6;
  localparam logic [3:0]  PHASE_ZERO   = 4'h0;
  localparam logic [7:0]  DATA_ZERO    = 8'h00;
  localparam logic [7:0]  MASK7        = 8'h7f;
  localparam logic [7:0]  DIV_ZERO     = 8'h00;

  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_EXTRA, TX_STOP} tx_state_e;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_EXTRA, RX_STOP} rx_state_e;

  typedef struct packed {
    logic charLengthSel;
    logic parityEnable;
    logic parityOdd;
    logic multiprocMode;
    logic stopTwo;
    logic clockEnableHi;
    logic clockEnableLo;
    logic transmitEnable;
    logic receiveEnable;
    logic txIrqEnable;
    logic txEndIrqEnable;
    logic rxIrqEnable;
  } cfg_s;

  typedef struct packed {
    logic txWrite;
    logic [7:0] txWriteData;
    logic multiprocBitTx;
    logic clrRxFull;
    logic clrOverrun;
    logic clrFraming;
    logic clrParity;
  } sw_s;

  typedef struct packed {
    logic txDataEmpty;
    logic txEndFlag;
    logic rxFullFlag;
    logic overrunFlag;
    logic framingErrFlag;
    logic parityErrFlag;
    logic multiprocBit;
  } flags_s;

  typedef struct packed {
    logic txEmptyIrq;
    logic txEndIrq;
    logic rxFullIrq;
    logic rxErrorIrq;
  } irq_s;

  localparam flags_s FLAGS_RESET = '{txDataEmpty: 1'b1, txEndFlag: 1'b1, default: 1'b0};

endpackage

// *** baud_tick_gen.sv ***
// Purpose: Sixteen-times basic clock tick from divider or pin
// Assumes: Pin clock is synchronous to sys_clk
// Notes:   Tick is a one-cycle pulse from a flop
`timescale 1ns/1ps
module baud_tick_gen (
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic       useExternal,
  input  wire logic [7:0] baudDivisor,
  input  wire logic       sclkIn,
  output logic            tick
);

  typedef struct packed {
    logic [7:0] count;
    logic       pinLast;
    logic       tick;
  } tick_state_s;

  localparam logic [7:0] DIV_ZERO_L = serial_comm_pkg::DIV_ZERO;

  tick_state_s q;
  tick_state_s d;

  always_comb begin
    d = q;
    d.pinLast = sclkIn;
    if (useExternal) begin
      // Pin must run at sixteen times the bit rate
      d.tick = sclkIn & ~q.pinLast; // RULE7 RULE6
      d.count = baudDivisor;
    end else begin
      d.tick = (q.count == DIV_ZERO_L); // RULE6
      d.count = (q.count == DIV_ZERO_L) ? baudDivisor : q.count - 8'h01;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign tick = q.tick;

  chk_ext_edge: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (useExternal && sclkIn && !q.pinLast) |=> tick) // RULE7
    else $error("external edge gave no tick");

endmodule

// *** async_serial_transceiver.sv ***
// Purpose: Asynchronous full-duplex transmitter and receiver
// Assumes: Config changes only with both directions disabled
// Notes:   Interrupt requests are levels, gated by their enables
`timescale 1ns/1ps
module async_serial_transceiver (
  input  wire logic                    sys_clk,
  input  wire logic                    rst_n,
  input  wire serial_comm_pkg::cfg_s   cfg,
  input  wire serial_comm_pkg::sw_s    sw,
  input  wire logic [7:0]              baudDivisor,
  input  wire logic                    rxd,
  input  wire logic                    sclkIn,
  output logic                         txd,
  output logic                         sclkOut,
  output logic                         sclkOe,
  output serial_comm_pkg::flags_s      flags,
  output logic [7:0]                   rxDataReg,
  output serial_comm_pkg::irq_s        irq
);

  typedef struct packed {
    serial_comm_pkg::tx_state_e txState;
    logic [3:0]                 txPhase;
    logic [2:0]                 txBit;
    logic [7:0]                 txShiftReg;
    logic [7:0]                 txDataReg;
    logic                       txMpbHold;
    logic                       txExtra;
    logic                       txChain;
    logic                       txSecond;
    logic                       txd;
    logic                       sclk;
    logic                       sclkOe;
    serial_comm_pkg::rx_state_e rxState;
    logic [3:0]                 rxCnt;
    logic [2:0]                 rxBit;
    logic [7:0]                 rxShiftReg;
    logic                       rxExtra;
    logic [7:0]                 rxDataReg;
    serial_comm_pkg::flags_s    flags;
    serial_comm_pkg::irq_s      irq;
  } xcvr_state_s;

  xcvr_state_s q;
  xcvr_state_s d;
  logic        tick;
  logic        txBoundary;
  logic        rxSample;
  logic        txLoad;
  logic        enterStop;
  logic        rxDone;
  logic        hasExtra;
  logic [2:0]  dataLast;
  logic [7:0]  rxWord;
  logic        parityBad;
  logic        frameBad;
  logic        rxErr;

  // External clock only when the high clock-enable is set
  baud_tick_gen u_tick (
    .sys_clk     (sys_clk),
    .rst_n       (rst_n),
    .useExternal (cfg.clockEnableHi),
    .baudDivisor (baudDivisor),
    .sclkIn      (sclkIn),
    .tick        (tick)
  );

  always_comb begin
    d = q;
    txLoad = 1'b0;
    enterStop = 1'b0;
    rxDone = 1'b0;
    txBoundary = tick && (q.txPhase == serial_comm_pkg::BIT_LAST);
    rxSample = tick && (q.rxCnt == serial_comm_pkg::SAMPLE_PHASE); // RULE5
    dataLast = cfg.charLengthSel ? serial_comm_pkg::LAST_BIT7
                                 : serial_comm_pkg::LAST_BIT8; // RULE2
    hasExtra = cfg.multiprocMode | cfg.parityEnable; // RULE3
    // Seven-bit frames end up one place high in the shifter
    rxWord = cfg.charLengthSel ? {1'b0, q.rxShiftReg[7:1]} : q.rxShiftReg;
    parityBad = cfg.parityEnable && !cfg.multiprocMode
                && (^rxWord ^ q.rxExtra ^ cfg.parityOdd); // RULE3
    frameBad = !rxd;
    rxErr = q.flags.overrunFlag | q.flags.framingErrFlag | q.flags.parityErrFlag;

    if (tick) begin
      d.txPhase = q.txPhase + 4'h1;
      d.rxCnt = q.rxCnt + 4'h1;
    end

    // Software writes and clears first, so hardware sets win
    if (sw.txWrite) begin
      d.txDataReg = sw.txWriteData;
      d.txMpbHold = sw.multiprocBitTx;
      d.flags.txDataEmpty = 1'b0;
    end
    if (sw.clrRxFull) begin
      d.flags.rxFullFlag = 1'b0;
    end
    if (sw.clrOverrun) begin
      d.flags.overrunFlag = 1'b0;
    end
    if (sw.clrFraming) begin
      d.flags.framingErrFlag = 1'b0;
    end
    if (sw.clrParity) begin
      d.flags.parityErrFlag = 1'b0;
    end

    case (q.txState)
      serial_comm_pkg::TX_IDLE: begin
        if (txBoundary && cfg.transmitEnable && !q.flags.txDataEmpty) begin
          txLoad = 1'b1; // RULE13
          d.flags.txEndFlag = 1'b0;
          d.txState = serial_comm_pkg::TX_START;
        end
      end
      serial_comm_pkg::TX_START: begin
        if (txBoundary) begin
          d.txBit = 3'h0;
          d.txState = serial_comm_pkg::TX_DATA; // RULE14
        end
      end
      serial_comm_pkg::TX_DATA: begin
        if (txBoundary) begin
          d.txShiftReg = q.txShiftReg >> 1; // RULE23
          d.txBit = q.txBit + 3'h1;
          if (q.txBit == dataLast) begin
            if (hasExtra) begin
              d.txState = serial_comm_pkg::TX_EXTRA; // RULE14
            end else begin
              enterStop = 1'b1;
            end
          end
        end
      end
      serial_comm_pkg::TX_EXTRA: begin
        if (txBoundary) begin
          enterStop = 1'b1;
        end
      end
      serial_comm_pkg::TX_STOP: begin
        if (txBoundary) begin
          if (cfg.stopTwo && !q.txSecond) begin
            d.txSecond = 1'b1; // RULE4
          end else if (q.txChain) begin
            d.txState = serial_comm_pkg::TX_START; // RULE15
          end else begin
            d.txState = serial_comm_pkg::TX_IDLE; // RULE16
          end
        end
      end
      default: begin
        d.txState = serial_comm_pkg::TX_IDLE;
      end
    endcase

    if (enterStop) begin
      d.txState = serial_comm_pkg::TX_STOP;
      d.txSecond = 1'b0;
      d.txChain = !q.flags.txDataEmpty; // RULE15
      if (q.flags.txDataEmpty) begin
        d.flags.txEndFlag = 1'b1; // RULE16
      end else begin
        txLoad = 1'b1; // RULE15
      end
    end

    if (txLoad) begin
      d.txShiftReg = cfg.charLengthSel ? (q.txDataReg & serial_comm_pkg::MASK7)
                                       : q.txDataReg;
      // Multiprocessor bit replaces parity when that mode is on
      d.txExtra = cfg.multiprocMode ? q.txMpbHold
                : (^(d.txShiftReg) ^ cfg.parityOdd); // RULE3
      d.flags.txDataEmpty = 1'b1; // RULE13
    end

    if (!cfg.transmitEnable) begin
      d.flags.txDataEmpty = 1'b1; // RULE9
      d.txState = serial_comm_pkg::TX_IDLE;
    end

    case (d.txState)
      serial_comm_pkg::TX_START: d.txd = 1'b0; // RULE14
      serial_comm_pkg::TX_DATA:  d.txd = d.txShiftReg[0]; // RULE23
      serial_comm_pkg::TX_EXTRA: d.txd = d.txExtra;
      default:                   d.txd = 1'b1; // RULE16
    endcase
    // Bit-rate clock high in the second half of each bit
    d.sclk = d.txPhase[3]; // RULE8
    d.sclkOe = cfg.clockEnableLo && !cfg.clockEnableHi; // RULE8 RULE6

    case (q.rxState)
      serial_comm_pkg::RX_IDLE: begin
        d.rxCnt = serial_comm_pkg::PHASE_ZERO;
        // Held off while any error flag is still up
        if (tick && cfg.receiveEnable && !rxd && !rxErr) begin // RULE1 RULE22
          d.rxState = serial_comm_pkg::RX_START;
        end
      end
      serial_comm_pkg::RX_START: begin
        if (rxSample) begin
          d.rxBit = 3'h0;
          // A start that is high at mid-bit was a glitch
          d.rxState = rxd ? serial_comm_pkg::RX_IDLE
                          : serial_comm_pkg::RX_DATA; // RULE5
        end
      end
      serial_comm_pkg::RX_DATA: begin
        if (rxSample) begin
          d.rxShiftReg = {rxd, q.rxShiftReg[7:1]}; // RULE23
          d.rxBit = q.rxBit + 3'h1;
          if (q.rxBit == dataLast) begin
            d.rxState = hasExtra ? serial_comm_pkg::RX_EXTRA
                                 : serial_comm_pkg::RX_STOP;
          end
        end
      end
      serial_comm_pkg::RX_EXTRA: begin
        if (rxSample) begin
          d.rxExtra = rxd;
          d.rxState = serial_comm_pkg::RX_STOP;
        end
      end
      serial_comm_pkg::RX_STOP: begin
        if (rxSample) begin
          // A frame ending as receive is disabled must not touch flags
          rxDone = cfg.receiveEnable; // RULE1 RULE10
          d.rxState = serial_comm_pkg::RX_IDLE;
        end
      end
      default: begin
        d.rxState = serial_comm_pkg::RX_IDLE;
      end
    endcase

    if (rxDone) begin
      if (q.flags.rxFullFlag) begin
        d.flags.overrunFlag = 1'b1; // RULE17
      end else begin
        d.rxDataReg = rxWord; // RULE18 RULE19
        if (cfg.multiprocMode) begin
          d.flags.multiprocBit = q.rxExtra;
        end
        if (!parityBad && !frameBad) begin
          d.flags.rxFullFlag = 1'b1; // RULE20 RULE21
        end
      end
      if (parityBad) begin
        d.flags.parityErrFlag = 1'b1; // RULE18
      end
      if (frameBad) begin
        d.flags.framingErrFlag = 1'b1; // RULE19
      end
    end

    // Only the sequencer stops; flags and data are left alone
    if (!cfg.receiveEnable) begin
      d.rxState = serial_comm_pkg::RX_IDLE; // RULE10
    end

    d.irq.txEmptyIrq = cfg.txIrqEnable && cfg.transmitEnable && d.flags.txDataEmpty; // RULE13
    d.irq.txEndIrq = cfg.txEndIrqEnable && d.flags.txEndFlag; // RULE16
    d.irq.rxFullIrq = cfg.rxIrqEnable && d.flags.rxFullFlag; // RULE20
    d.irq.rxErrorIrq = cfg.rxIrqEnable && (d.flags.overrunFlag
                       | d.flags.framingErrFlag | d.flags.parityErrFlag); // RULE17
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '{txState: serial_comm_pkg::TX_IDLE,
             rxState: serial_comm_pkg::RX_IDLE,
             txd: 1'b1,
             flags: serial_comm_pkg::FLAGS_RESET,
             default: '0};
    end else begin
      q <= d;
    end
  end

  assign txd = q.txd;
  assign sclkOut = q.sclk;
  assign sclkOe = q.sclkOe;
  assign flags = q.flags;
  assign rxDataReg = q.rxDataReg;
  assign irq = q.irq;

  chk_te_off_empty: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE9
    !cfg.transmitEnable |=> flags.txDataEmpty && q.txState == serial_comm_pkg::TX_IDLE)
    else $error("transmit disable left data-empty low");

  chk_re_off_hold: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE10
    (!cfg.receiveEnable && !sw.clrRxFull && !sw.clrOverrun && !sw.clrFraming
     && !sw.clrParity) |=> $stable(rxDataReg) && $stable(flags.rxFullFlag)
     && $stable(flags.overrunFlag) && $stable(flags.framingErrFlag))
    else $error("receive disable changed receive state");

  chk_load_empty: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE13
    (txLoad && cfg.transmitEnable) |=> flags.txDataEmpty
     && q.txShiftReg[6:0] == $past(q.txDataReg[6:0]))
    else $error("load did not set data-empty");

  chk_start_low: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE14
    q.txState == serial_comm_pkg::TX_START |-> !txd)
    else $error("start bit not low");

  chk_idle_high: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE16
    (q.txState == serial_comm_pkg::TX_IDLE || q.txState == serial_comm_pkg::TX_STOP)
     |-> txd)
    else $error("line not high in stop or idle");

  chk_end_flag: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE16
    (enterStop && q.flags.txDataEmpty && cfg.transmitEnable) |=> flags.txEndFlag)
    else $error("end flag not set at stop time");

  chk_sclk_mid: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE8
    $rose(sclkOut) |-> q.txPhase == serial_comm_pkg::CLK_RISE)
    else $error("output clock rose off mid-bit");

  chk_overrun_keep: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE17
    (rxDone && q.flags.rxFullFlag) |=> flags.overrunFlag && flags.rxFullFlag
     && $stable(rxDataReg))
    else $error("overrun handling wrong");

  chk_frame_err: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE19
    (rxDone && frameBad) |=> flags.framingErrFlag)
    else $error("low stop bit not flagged");

  chk_good_rx: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE20
    (rxDone && !frameBad && !parityBad && !q.flags.rxFullFlag)
     |=> flags.rxFullFlag && rxDataReg == $past(rxWord))
    else $error("clean frame not stored");

  chk_err_full: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE21
    (rxDone && (frameBad || parityBad) && !sw.clrRxFull)
     |=> flags.rxFullFlag == $past(q.flags.rxFullFlag))
    else $error("error changed full flag");

  chk_rx_blocked: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE22
    (q.rxState == serial_comm_pkg::RX_IDLE && rxErr) |=> q.rxState == serial_comm_pkg::RX_IDLE)
    else $error("reception resumed with error flag set");

  cov_tx_end: cover property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(flags.txEndFlag));
  cov_tx_chain: cover property (@(posedge sys_clk) disable iff (!rst_n)
    enterStop && !q.flags.txDataEmpty);
  cov_rx_good: cover property (@(posedge sys_clk) disable iff (!rst_n)
    rxDone && !frameBad && !parityBad && !q.flags.rxFullFlag);
  cov_overrun: cover property (@(posedge sys_clk) disable iff (!rst_n)
    rxDone && q.flags.rxFullFlag);

endmodule

// *** serial_station.sv ***
// Purpose: Remote serial station on the far side of txd and rxd
// Assumes: bitLen sys_clk cycles per bit, receive line pulled up when released
// Notes:   Records the frames it hears and sends frames on request
`timescale 1ns/1ps
module serial_station (
  input  wire logic sys_clk,
  input  wire logic rst_n,
  input  wire logic txd,
  output logic      rxd,
  output logic      sclkIn
);
  int          bitLen = 32;
  int          rxBits = 10;
  logic [11:0] frQ[$];
  time         tQ[$];
  logic [11:0] fr;
  time         t0;

  initial begin
    rxd    = 1'b1;
    sclkIn = 1'b0;
  end

  // Runs free, also through reset and setup: ticks every 2 clocks
  always @(posedge sys_clk) sclkIn <= ~sclkIn;

  // Samples mid-bit; resyncs on each start bit's falling edge, so chained frames are seen
  initial forever begin
    @(posedge sys_clk);
    if (rst_n === 1'b1 && txd === 1'b0) begin
      t0 = $time;
      fr = '0;
      repeat (bitLen / 2) @(posedge sys_clk);
      for (int i = 0; i < rxBits; i++) begin
        fr[i] = txd;
        if (i < rxBits - 1) repeat (bitLen) @(posedge sys_clk);
      end
      frQ.push_back(fr);
      tQ.push_back(t0);
    end
  end

  // Edges of every bit but the start and last bits inverted for q clocks to probe the sample point
  // Last bit kept clean: a low tail there would look like a new start
  task automatic send(input logic [11:0] f, input int n, input int q);
    for (int i = 0; i < n; i++) begin
      for (int c = 0; c < bitLen; c++) begin
        rxd <= (i > 0 && i < n - 1 && (c < q || c >= bitLen - q)) ? ~f[i] : f[i];
        @(posedge sys_clk);
      end
    end
    rxd <= 1'b1;
  endtask
endmodule

// *** async_serial_transceiver_tb.sv ***
// Purpose: Self-checking bench for the serial transceiver
// Assumes: baudDivisor 1 or pin clock toggling each cycle: 32 clocks a bit
// Notes:   Station model decodes txd and drives rxd
`timescale 1ns/1ps
module async_serial_transceiver_tb;
  logic                    sys_clk, rst_n, txd, rxd, sclkIn, sclkOut, sclkOe;
  logic [7:0]              baudDivisor, rxDataReg;
  serial_comm_pkg::cfg_s   cfg;
  serial_comm_pkg::sw_s    sw;
  serial_comm_pkg::flags_s flags;
  serial_comm_pkg::irq_s   irq;
  int                      error_cnt, cmp_count, n, k;
  logic [11:0]             f, g;

  async_serial_transceiver dut (.sys_clk(sys_clk), .rst_n(rst_n), .cfg(cfg), .sw(sw),
    .baudDivisor(baudDivisor), .rxd(rxd), .sclkIn(sclkIn), .txd(txd), .sclkOut(sclkOut),
    .sclkOe(sclkOe), .flags(flags), .rxDataReg(rxDataReg), .irq(irq));
  serial_station station (.sys_clk(sys_clk), .rst_n(rst_n), .txd(txd), .rxd(rxd),
    .sclkIn(sclkIn));

  task automatic chkv(input logic [11:0] got, input logic [11:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chkn(input int got, input int exp);
    cmp_count++;
    if (got != exp) begin
      error_cnt++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int c);
    repeat (c) @(posedge sys_clk);
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // b = {7 bits, parity, odd, multiproc, two stops, pin clock, clock out}
  function automatic serial_comm_pkg::cfg_s mc(input logic [6:0] b);
    return {b, 5'h1f};
  endfunction
  function automatic logic [11:0] mk(input logic [7:0] d, input logic [6:0] b,
                                     input logic mb, output int len);
    logic [11:0] r;
    r = '0;
    r[8:1] = b[6] ? {1'b0, d[6:0]} : d;
    len = b[6] ? 8 : 9;
    if (b[3] || b[5]) begin
      r[len] = b[3] ? mb : ^(d & (b[6] ? 8'h7f : 8'hff)) ^ b[4];
      len = len + 1;
    end
    r[len] = 1'b1;
    r[len + 1] = b[2];
    len = len + 1 + int'(b[2]);
    return r;
  endfunction
  // Format changes only with both directions off
  task automatic setcfg(input serial_comm_pkg::cfg_s c);
    cfg.transmitEnable <= 1'b0;
    cfg.receiveEnable  <= 1'b0;
    cyc(2);
    cfg <= {c[11:5], 2'h0, c[2:0]};
    cyc(2);
    cfg <= c;
    cyc(2);
  endtask
  task automatic wrtx(input logic [7:0] d, input logic mb);
    sw.txWrite        <= 1'b1;
    sw.txWriteData    <= d;
    sw.multiprocBitTx <= mb;
    cyc(1);
    sw.txWrite <= 1'b0;
    cyc(1);
  endtask
  // m = {full, overrun, framing, parity}
  task automatic clr(input logic [3:0] m);
    {sw.clrRxFull, sw.clrOverrun, sw.clrFraming, sw.clrParity} <= m;
    cyc(1);
    {sw.clrRxFull, sw.clrOverrun, sw.clrFraming, sw.clrParity} <= 4'h0;
    cyc(2);
  endtask
  task automatic getfr(output logic [11:0] r);
    for (int i = 0; i < 2000 && station.frQ.size() == 0; i++) cyc(1);
    if (station.frQ.size() > 0)
      r = station.frQ.pop_front();
    else
      r = 12'hfff;
  endtask

  task automatic t_txfmt();
    logic [6:0] b;
    logic [7:0] d;
    for (int i = 0; i < 12; i++) begin
      b = {i[0], i[3:2] == 2'h1, i[0] ^ i[1], i[3:2] == 2'h2, i[1], 2'h0};
      d = 8'h96 ^ 8'(i);
      setcfg(mc(b));
      f = mk(d, b, i[1], n);
      station.rxBits = n;
      wrtx(d, i[1]);
      getfr(g);
      chkv(g, f);
      chkv(flags.txDataEmpty, 1'b1);
      chkv(flags.txEndFlag, 1'b1);
      cyc(40);
    end
    $display("test txfmt done");
  endtask
  task automatic t_chain();
    setcfg(mc(7'h00));
    station.rxBits = 10;
    station.tQ.delete();
    wrtx(8'h11, 1'b0);
    for (k = 0; k < 200 && flags.txDataEmpty !== 1'b1; k++) cyc(1);
    wrtx(8'h22, 1'b0);
    chkv(flags.txDataEmpty, 1'b0);
    getfr(g);
    chkv(g, mk(8'h11, 7'h00, 1'b0, n));
    getfr(g);
    chkv(g, mk(8'h22, 7'h00, 1'b0, n));
    chkn(int'(station.tQ[1] - station.tQ[0]), 3200);
    cyc(5);
    chkv({flags.txEndFlag, irq.txEndIrq, irq.txEmptyIrq}, 3'h7);
    cfg.transmitEnable <= 1'b0;
    cfg.txEndIrqEnable <= 1'b0;
    cyc(2);
    wrtx(8'h77, 1'b0);
    cyc(2);
    chkv({flags.txDataEmpty, irq.txEndIrq, irq.txEmptyIrq}, 3'h4);
    cyc(400);
    chkn(station.frQ.size(), 0);
    $display("test chain done");
  endtask
  task automatic t_rxerr();
    setcfg(mc(7'h28));
    station.send(mk(8'h3c, 7'h28, 1'b1, n), n, 8);
    cyc(3);
    chkv(rxDataReg, 8'h3c);
    chkv({flags.rxFullFlag, flags.multiprocBit, flags.parityErrFlag}, 3'h6);
    chkv(irq.rxFullIrq, 1'b1);
    station.send(mk(8'hc3, 7'h28, 1'b0, n), n, 0);
    cyc(3);
    chkv(rxDataReg, 8'h3c);
    chkv({flags.rxFullFlag, flags.overrunFlag}, 2'h3);
    chkv(irq.rxErrorIrq, 1'b1);
    cfg.receiveEnable <= 1'b0;
    cyc(3);
    chkv({rxDataReg, flags.rxFullFlag, flags.overrunFlag}, 10'h0f3);
    cfg.receiveEnable <= 1'b1;
    clr(4'h8);
    station.send(mk(8'h99, 7'h28, 1'b1, n), n, 0);
    cyc(3);
    chkv({rxDataReg, flags.rxFullFlag}, 9'h078);
    clr(4'hf);
    setcfg(mc(7'h70));
    f = mk(8'hda, 7'h70, 1'b0, n);
    f[8] = ~f[8];
    station.send(f, n, 0);
    cyc(3);
    chkv(rxDataReg, 8'h5a);
    chkv({flags.rxFullFlag, flags.parityErrFlag, irq.rxErrorIrq}, 3'h3);
    clr(4'hf);
    setcfg(mc(7'h00));
    f = mk(8'h81, 7'h00, 1'b0, n);
    f[9] = 1'b0;
    station.send(f, n, 0);
    cyc(3);
    chkv(rxDataReg, 8'h81);
    chkv({flags.rxFullFlag, flags.framingErrFlag}, 2'h1);
    clr(4'hf);
    chkv(flags[4:1], 4'h0);
    $display("test rxerr done");
  endtask
  task automatic t_clk();
    logic p;
    setcfg(mc(7'h01));
    chkv(sclkOe, 1'b1);
    station.rxBits = 10;
    wrtx(8'h0f, 1'b0);
    for (k = 0; k < 200 && txd !== 1'b0; k++) cyc(1);
    p = 1'b1;
    for (k = 0; k < 64 && !(sclkOut === 1'b1 && p === 1'b0); k++) begin
      p = sclkOut;
      cyc(1);
    end
    chkn(k, 16);
    getfr(g);
    baudDivisor <= 8'h05;
    setcfg(mc(7'h02));
    chkv(sclkOe, 1'b0);
    wrtx(8'h69, 1'b0);
    getfr(g);
    chkv(g, mk(8'h69, 7'h02, 1'b0, n));
    $display("test clk done");
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // Whole run is some 8000 cycles
  initial begin
    #400000;
    error_cnt++;
    give_verdict();
  end
  initial begin
    rst_n       = 1'b0;
    cfg         = '0;
    sw          = '0;
    baudDivisor = 8'h01;
    cyc(4);
    rst_n <= 1'b1;
    cyc(1);
    chkv(flags, serial_comm_pkg::FLAGS_RESET);
    chkv({txd, sclkOut, sclkOe, irq}, 7'h40);
    chkv(rxDataReg, 8'h00);
    t_txfmt();
    t_chain();
    t_rxerr();
    t_clk();
    give_verdict();
  end
endmodule
